// ---- design/rsc_consts.vh ----
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
// reset cause selector codes, one-hot
`define RSC_CAUSE_POR 3'h1
`define RSC_CAUSE_RUN_WDT 3'h2
`define RSC_CAUSE_HALT_WDT 3'h4
// register reset values
`define RSC_PC_RESET 8'h00
`define RSC_SP_RESET 3'h0
`define RSC_WATCHDOG_CONTROL_REG_RESET 8'h53
`define RSC_PORT_DATA_RESET 8'hFF
`define RSC_PORT_DIR_RESET 8'hFF
`define RSC_PULLUP_RESET 8'h00
`define RSC_ADC_PIN_RESET 4'hF
// status register bit positions
`define RSC_STATUS_TO_BIT 5
`define RSC_STATUS_PDF_BIT 4
// settle counts in oscillator clocks (upper bound of 15~16 and 1~2)
`define RSC_SETTLE_FAST 5'h10
`define RSC_SETTLE_SLOW 5'h02
// low-voltage qualifying time in core cycles
`define RSC_LV_QUAL 8'h0A
`endif

// ---- design/rsc_settle.v ----
`timescale 1ns/10ps
// counts oscillator enable pulses for the wake settle delay
module rsc_settle (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_start,
  input wire i_osc_tick,
  input wire [4:0] i_count,
  output reg o_busy
);
  reg [4:0] left; // ticks still to wait

  // load on start, count oscillator ticks down to zero
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left <= 5'h00;
      o_busy <= 1'b0;
    end else if (i_start) begin
      left <= i_count;
      o_busy <= 1'b1;
    end else if (o_busy && i_osc_tick) begin
      left <= left - 5'h01;
      if (left == 5'h01) begin
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// ---- design/rsc_reset_ctrl.v ----
`timescale 1ns/10ps
// How it works
// - running watchdog reset equals low-voltage reset plus timeout
// - halted watchdog clears pc, sp, sets timeout
// - fast oscillator waits 15 to 16 clocks
// - slow oscillator waits 1 to 2 clocks
// - timeout and powerdown flags live in status
// - power-on clears flags; low-voltage keeps them
// - running sets timeout; halted sets both flags
// - power-on zeroes pc, disables all interrupts
// - power-on clears watchdog, counting starts at once
// - power-on switches timer/event counter off
// - ports input, analog pins assigned, stack top
// - every reset loads pc low byte zero
// - watchdog control reloaded except halted watchdog
// - running keeps acc, table pointer; pointers unknown
// - ports ones, pullups zero; halted keeps them
// - low-voltage reset needs qualified persistence, sets flag
`include "rsc_consts.vh"
module rsc_reset_ctrl (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_wdt_timeout,
  input wire i_halted,
  input wire i_halt_enter,
  input wire i_low_voltage,
  input wire i_fast_internal_osc,
  input wire i_osc_tick,
  output reg [2:0] o_cause,
  output reg o_init_pulse,
  output reg o_cpu_hold,
  output reg o_timeout_flag,
  output reg o_powerdown_flag,
  output reg o_low_voltage_flag,
  output reg [7:0] o_pc_low_byte,
  output reg [2:0] o_stack_ptr,
  output reg o_int_enable_clr,
  output reg o_wdt_clear,
  output reg o_timer_off,
  output reg [7:0] o_watchdog_control_reg,
  output reg [7:0] o_port_data,
  output reg [7:0] o_port_dir,
  output reg [7:0] o_port_pullup,
  output reg [3:0] o_analog_inputs_0_to_3,
  output reg o_keep_acc_tbl,
  output reg o_ptr_unknown
);
  // fsm states, one-hot
  localparam ST_POR = 3'h1;
  localparam ST_RUN = 3'h2;
  localparam ST_SETTLE = 3'h4;

  // halted-mode time-out seen while running; shared by fsm and policy
  function halt_wdt_hit;
    input [2:0] st; // current sequencer state
    input rise; // synchronised time-out edge
    input halted; // synchronised halted level
    begin
      halt_wdt_hit = (st == ST_RUN) && rise && halted;
    end
  endfunction

  reg rst_m; // reset release stage one
  reg rst_n; // synchronised reset
  reg [1:0] wdt_s; // pin synchronisers
  reg [1:0] halt_s;
  reg [1:0] lv_s;
  reg [1:0] fast_s;
  reg [2:0] state; // sequencer state
  reg [2:0] next_state;
  reg [7:0] lv_cnt; // low-voltage persistence counter
  reg wdt_q; // delayed watchdog for edge detect
  reg settle_start; // kicks the settle counter
  wire settle_busy; // settle counter running
  wire wdt_rise; // new watchdog time-out
  wire lv_fire; // qualified low-voltage event

  // release reset through two flops
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // two-stage synchronisers; first stage read only by second
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_s <= 2'h0;
      halt_s <= 2'h0;
      lv_s <= 2'h0;
      fast_s <= 2'h0;
      wdt_q <= 1'b0;
    end else begin
      wdt_s <= {wdt_s[0], i_wdt_timeout};
      halt_s <= {halt_s[0], i_halted};
      lv_s <= {lv_s[0], i_low_voltage};
      fast_s <= {fast_s[0], i_fast_internal_osc};
      wdt_q <= wdt_s[1];
    end
  end

  assign wdt_rise = wdt_s[1] & ~wdt_q;
  // fires once, when the count reaches one below the qualifying time
  assign lv_fire = lv_s[1] && (lv_cnt == `RSC_LV_QUAL - 8'h01);

  // low-voltage persistence; disabled while halted
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lv_cnt <= 8'h00;
    end else if (!lv_s[1] || halt_s[1]) begin
      lv_cnt <= 8'h00; // short dips are ignored
    end else if (lv_cnt != `RSC_LV_QUAL) begin
      lv_cnt <= lv_cnt + 8'h01;
    end
  end

  // sequencer next state
  always @* begin
    next_state = state;
    settle_start = 1'b0;
    case (state)
      ST_POR: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (halt_wdt_hit(state, wdt_rise, halt_s[1])) begin
          next_state = ST_SETTLE;
          settle_start = 1'b1;
        end
      end
      ST_SETTLE: begin
        // hold is registered, so it drops one cycle after busy clears
        if (!settle_busy) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
  end

  // settle count picked by the running oscillator
  rsc_settle u_settle (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_start(settle_start),
    .i_osc_tick(i_osc_tick),
    .i_count(fast_s[1] ? `RSC_SETTLE_FAST : `RSC_SETTLE_SLOW),
    .o_busy(settle_busy)
  );

  // cause selection and per-cause register policy
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_POR;
      o_cause <= `RSC_CAUSE_POR;
      o_init_pulse <= 1'b1;
      o_cpu_hold <= 1'b1;
      o_timeout_flag <= 1'b0;
      o_powerdown_flag <= 1'b0;
      o_low_voltage_flag <= 1'b0;
      o_pc_low_byte <= `RSC_PC_RESET;
      o_stack_ptr <= `RSC_SP_RESET;
      o_int_enable_clr <= 1'b1;
      o_wdt_clear <= 1'b1;
      o_timer_off <= 1'b1;
      o_watchdog_control_reg <= `RSC_WATCHDOG_CONTROL_REG_RESET;
      o_port_data <= `RSC_PORT_DATA_RESET;
      o_port_dir <= `RSC_PORT_DIR_RESET;
      o_port_pullup <= `RSC_PULLUP_RESET;
      o_analog_inputs_0_to_3 <= `RSC_ADC_PIN_RESET;
      o_keep_acc_tbl <= 1'b0;
      o_ptr_unknown <= 1'b1;
    end else begin
      state <= next_state;
      o_init_pulse <= 1'b0;
      o_int_enable_clr <= 1'b0;
      o_wdt_clear <= 1'b0; // one pulse, then watchdog counts
      // hold the core only while settling
      o_cpu_hold <= (next_state == ST_SETTLE);
      if (i_halt_enter) begin
        o_powerdown_flag <= 1'b1; // halt entry sets the flag
        o_timeout_flag <= 1'b0;
      end
      if (halt_wdt_hit(state, wdt_rise, halt_s[1])) begin
        // halted watchdog: only pc and sp reload; both flags set
        o_cause <= `RSC_CAUSE_HALT_WDT;
        o_init_pulse <= 1'b1;
        o_pc_low_byte <= `RSC_PC_RESET;
        o_stack_ptr <= `RSC_SP_RESET;
        o_timeout_flag <= 1'b1;
        o_powerdown_flag <= 1'b1;
        o_keep_acc_tbl <= 1'b1;
        o_ptr_unknown <= 1'b0;
      end else if (state == ST_RUN && (wdt_rise || lv_fire)) begin
        // full reset as low-voltage; watchdog adds timeout
        o_cause <= `RSC_CAUSE_RUN_WDT;
        o_init_pulse <= 1'b1;
        o_pc_low_byte <= `RSC_PC_RESET;
        o_stack_ptr <= `RSC_SP_RESET;
        o_int_enable_clr <= 1'b1;
        o_wdt_clear <= 1'b1;
        o_timer_off <= 1'b1;
        o_watchdog_control_reg <= `RSC_WATCHDOG_CONTROL_REG_RESET;
        o_port_data <= `RSC_PORT_DATA_RESET;
        o_port_dir <= `RSC_PORT_DIR_RESET;
        o_port_pullup <= `RSC_PULLUP_RESET;
        o_analog_inputs_0_to_3 <= `RSC_ADC_PIN_RESET;
        o_keep_acc_tbl <= 1'b1;
        o_ptr_unknown <= 1'b1;
        if (wdt_rise) begin
          o_timeout_flag <= 1'b1;
        end
        if (lv_fire) begin
          o_low_voltage_flag <= 1'b1;
        end
      end else if (state == ST_RUN) begin
        o_timer_off <= 1'b0;
      end
    end
  end
endmodule

// ---- dv/rsc_reset_ctrl_props.sv ----
`timescale 1ns/10ps
module rsc_props (
  input wire i_core_clk,
  input wire i_resetn,
  input wire [2:0] o_cause,
  input wire o_init_pulse,
  input wire o_cpu_hold,
  input wire o_timeout_flag,
  input wire o_powerdown_flag,
  input wire [7:0] o_pc_low_byte,
  input wire [2:0] o_stack_ptr,
  input wire [7:0] o_watchdog_control_reg,
  input wire [7:0] o_port_data,
  input wire [7:0] o_port_pullup,
  input wire o_keep_acc_tbl,
  input wire o_ptr_unknown
);
  // one clock domain, so one default clock and disable
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // init pulse decoded by cause
  wire halt_go = o_init_pulse && o_cause == 3'h4;
  wire run_go = o_init_pulse && o_cause == 3'h2;
  a_halt_flags_set: assert property (
    halt_go |-> o_timeout_flag && o_powerdown_flag)
    else $error("halted flags wrong");
  a_halt_clears_sp: assert property (
    halt_go |-> o_stack_ptr == 3'h0)
    else $error("stack not cleared");
  a_pc_every_reset: assert property (
    o_init_pulse |-> o_pc_low_byte == 8'h00)
    else $error("pc not cleared");
  a_halt_holds_cpu: assert property (
    halt_go |-> o_cpu_hold)
    else $error("no settle hold");
  a_halt_keeps_regs: assert property (
    halt_go |-> $stable(o_port_data) && $stable(o_watchdog_control_reg)
    && $stable(o_port_pullup))
    else $error("halted reset changed regs");
  a_run_reloads_regs: assert property (
    run_go |-> o_port_data == 8'hFF && o_watchdog_control_reg == 8'h53
    && o_port_pullup == 8'h00)
    else $error("run reset values wrong");
  a_cause_one_hot: assert property (
    $onehot(o_cause))
    else $error("cause not one-hot");
  // the power-on pulse stands through reset, so it is left out here
  a_pulse_single: assert property (
    o_init_pulse && o_cause != 3'h1 |=> !o_init_pulse)
    else $error("init pulse too long");
  a_run_keeps_acc: assert property (
    run_go |-> o_keep_acc_tbl && o_ptr_unknown)
    else $error("run keep policy wrong");
endmodule
bind rsc_reset_ctrl rsc_props i_props (
  .i_core_clk(i_core_clk),
  .i_resetn(i_resetn),
  .o_cause(o_cause),
  .o_init_pulse(o_init_pulse),
  .o_cpu_hold(o_cpu_hold),
  .o_timeout_flag(o_timeout_flag),
  .o_powerdown_flag(o_powerdown_flag),
  .o_pc_low_byte(o_pc_low_byte),
  .o_stack_ptr(o_stack_ptr),
  .o_watchdog_control_reg(o_watchdog_control_reg),
  .o_port_data(o_port_data),
  .o_port_pullup(o_port_pullup),
  .o_keep_acc_tbl(o_keep_acc_tbl),
  .o_ptr_unknown(o_ptr_unknown)
);

// ---- dv/rsc_reset_ctrl_test.sv ----
`timescale 1ns/10ps
module rsc_reset_ctrl_test;
  reg i_core_clk = 1'b0;
  reg i_resetn = 1'b0;
  reg i_wdt_timeout = 1'b0;
  reg i_halted = 1'b0;
  reg i_halt_enter = 1'b0;
  reg i_low_voltage = 1'b0;
  reg i_fast_internal_osc = 1'b1;
  reg i_osc_tick = 1'b0;
  reg [1:0] n4 = 2'h0;
  wire [2:0] o_cause, o_stack_ptr;
  wire o_init_pulse, o_cpu_hold, o_timeout_flag, o_powerdown_flag;
  wire o_low_voltage_flag, o_int_enable_clr, o_wdt_clear, o_timer_off;
  wire o_keep_acc_tbl, o_ptr_unknown;
  wire [7:0] o_pc_low_byte, o_watchdog_control_reg, o_port_data;
  wire [7:0] o_port_dir, o_port_pullup;
  wire [3:0] o_analog_inputs_0_to_3;
  integer errors = 0;
  integer comparisons = 0;
  integer n;
  rsc_reset_ctrl i_dut (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_wdt_timeout(i_wdt_timeout),
    .i_halted(i_halted),
    .i_halt_enter(i_halt_enter),
    .i_low_voltage(i_low_voltage),
    .i_fast_internal_osc(i_fast_internal_osc),
    .i_osc_tick(i_osc_tick),
    .o_cause(o_cause),
    .o_init_pulse(o_init_pulse),
    .o_cpu_hold(o_cpu_hold),
    .o_timeout_flag(o_timeout_flag),
    .o_powerdown_flag(o_powerdown_flag),
    .o_low_voltage_flag(o_low_voltage_flag),
    .o_pc_low_byte(o_pc_low_byte),
    .o_stack_ptr(o_stack_ptr),
    .o_int_enable_clr(o_int_enable_clr),
    .o_wdt_clear(o_wdt_clear),
    .o_timer_off(o_timer_off),
    .o_watchdog_control_reg(o_watchdog_control_reg),
    .o_port_data(o_port_data),
    .o_port_dir(o_port_dir),
    .o_port_pullup(o_port_pullup),
    .o_analog_inputs_0_to_3(o_analog_inputs_0_to_3),
    .o_keep_acc_tbl(o_keep_acc_tbl),
    .o_ptr_unknown(o_ptr_unknown)
  );
  always #20 i_core_clk = ~i_core_clk;
  // oscillator enable every fourth core clock
  always @(posedge i_core_clk) begin
    n4 <= n4 + 2'h1;
    i_osc_tick <= (n4 == 2'h3);
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // bounded wait on a level, sampled mid-cycle
  task wait_lvl(input reg want, input reg hold);
    begin
      n = 0;
      @(negedge i_core_clk);
      while ((hold ? o_cpu_hold : o_init_pulse) !== want && n < 200) begin
        @(negedge i_core_clk);
        n = n + 1;
      end
      // judge the level itself, not the loop count
      if ((hold ? o_cpu_hold : o_init_pulse) !== want) begin
        errors = errors + 1;
        print_verdict;
      end
    end
  endtask
  task t_run_wdt;
    begin
      @(posedge i_core_clk);
      i_wdt_timeout <= 1'b1;
      wait_lvl(1'b1, 1'b0);
      chk(o_cause, 3'h2);
      chk({o_timeout_flag, o_powerdown_flag}, 2'h2);
      chk(o_watchdog_control_reg, 8'h53);
      chk({o_keep_acc_tbl, o_ptr_unknown}, 2'h3);
      chk({o_int_enable_clr, o_wdt_clear, o_timer_off}, 3'h7);
      @(posedge i_core_clk);
      i_wdt_timeout <= 1'b0;
      wait_lvl(1'b0, 1'b1);
      $display("running watchdog done");
    end
  endtask
  // settle ticks are counted while the core is held
  task t_halt_wdt(input reg f, input integer lo, input integer hi);
    integer t;
    begin
      @(posedge i_core_clk);
      i_fast_internal_osc <= f;
      i_halt_enter <= 1'b1;
      i_halted <= 1'b1;
      @(posedge i_core_clk);
      i_halt_enter <= 1'b0;
      repeat (4) @(negedge i_core_clk);
      chk({o_timeout_flag, o_powerdown_flag}, 2'h1);
      @(posedge i_core_clk);
      i_wdt_timeout <= 1'b1;
      wait_lvl(1'b1, 1'b0);
      chk(o_cause, 3'h4);
      chk({o_timeout_flag, o_powerdown_flag}, 2'h3);
      chk({o_pc_low_byte, 5'h00, o_stack_ptr}, 16'h0000);
      chk(o_cpu_hold, 1'b1);
      // tick seen mid-cycle is consumed at the next rising edge
      t = 0;
      n = 0;
      while (o_cpu_hold === 1'b1 && n < 200) begin
        if (i_osc_tick === 1'b1) t = t + 1;
        @(negedge i_core_clk);
        n = n + 1;
      end
      if (o_cpu_hold === 1'b1) begin
        errors = errors + 1;
        print_verdict;
      end
      chk(t >= lo && t <= hi, 1'b1);
      @(posedge i_core_clk);
      i_wdt_timeout <= 1'b0;
      i_halted <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      $display("halted watchdog done");
    end
  endtask
  task t_low_voltage;
    begin
      i_low_voltage <= 1'b1;
      repeat (5) @(posedge i_core_clk);
      i_low_voltage <= 1'b0;
      repeat (20) @(negedge i_core_clk);
      chk({o_low_voltage_flag, o_cause}, 4'h4);
      @(posedge i_core_clk);
      i_low_voltage <= 1'b1;
      wait_lvl(1'b1, 1'b0);
      chk({o_low_voltage_flag, o_cause}, 4'hA);
      chk({o_timeout_flag, o_powerdown_flag}, 2'h3);
      @(posedge i_core_clk);
      i_low_voltage <= 1'b0;
      $display("low voltage done");
    end
  endtask
  // power-on in mid-run must clear flags left set by earlier resets
  task t_power_on;
    begin
      @(posedge i_core_clk);
      i_resetn <= 1'b0;
      repeat (2) @(negedge i_core_clk);
      chk({o_cause, o_timeout_flag, o_powerdown_flag}, 5'h04);
      chk(o_watchdog_control_reg, 8'h53);
      @(posedge i_core_clk);
      i_resetn <= 1'b1;
      repeat (4) @(negedge i_core_clk);
      chk({o_init_pulse, o_int_enable_clr, o_wdt_clear}, 3'h0);
      $display("mid-run power-on done");
    end
  endtask
  initial begin
    repeat (2) @(negedge i_core_clk);
    chk({o_cause, o_timeout_flag, o_powerdown_flag}, 5'h04);
    chk({o_int_enable_clr, o_wdt_clear, o_timer_off}, 3'h7);
    chk({o_port_dir, o_analog_inputs_0_to_3, o_stack_ptr}, 15'h7FF8);
    chk({o_port_data, o_port_pullup}, 16'hFF00);
    $display("power-on done");
    @(posedge i_core_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    t_run_wdt;
    t_halt_wdt(1'b1, 15, 16);
    t_halt_wdt(1'b0, 1, 2);
    t_low_voltage;
    t_power_on;
    print_verdict;
  end
endmodule
